// ===== verilog/clock_source_config.sv
// Clock source selection and configuration register
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_defs.svh"

module clock_source_config #(
    parameter int LONG_DELAY_CYCLES  = `LONG_DELAY_CYC,
    parameter int SHORT_DELAY_CYCLES = `SHORT_DELAY_CYC,
    parameter int WAKE_DELAY_CYCLES  = `INT_WAKE_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     power_reset,
    input  wire logic                     watchdog_reset,
    input  wire clock_source_pkg::io_req_t io_req,
    output logic [7:0]                    io_rdata,
    output logic                          io_rvalid,
    input  wire logic                     suspend_wake,
    input  wire logic                     ext_clk_stable,
    input  wire logic                     crystal_input_pin,
    input  wire logic                     crystal_output_pin_in,
    output logic                          crystal_output_pin_oe,
    output logic                          crystal_input_pulldown,
    output logic                          crystal_output_pulldown,
    output logic                          aux_port_bit1,
    output logic                          aux_port_bit2,
    output logic                          int_osc_enable,
    output logic                          ext_osc_run,
    output logic                          use_ext_clock,
    output logic                          cpu_clock_enable,
    output logic                          precision_tune_en,
    output logic                          low_volt_reset_en,
    output logic [2:0]                    wake_timer_adjust
);

    localparam int CW = 20;

    clock_source_pkg::clk_cfg_t   cfg_q;
    clock_source_pkg::clk_cfg_t   cfg_d;
    clock_source_pkg::clk_state_t st_q;
    clock_source_pkg::clk_state_t st_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;
    logic [7:0] wr_addr;
    logic       cfg_write;
    logic       ext_rising;
    logic       load;
    logic [CW-1:0] load_val;
    logic       expired;
    logic       xin_s1_q;
    logic       xin_s2_q;
    logic       xout_s1_q;
    logic       xout_s2_q;
    logic [14:0] outs_q;
    logic [14:0] outs_d;

    // Address decode; indexed write adds X
    always_comb
    begin
        wr_addr = io_req.wr_indexed ? 8'(io_req.addr + io_req.x_reg) : io_req.addr;
        cfg_write = (io_req.wr | io_req.wr_indexed) && (wr_addr == `CLK_CFG_ADDR);
    end

    // Register write and read data
    always_comb
    begin
        cfg_d = cfg_q;
        ext_rising = 1'b0;
        if (cfg_write)
        begin
            cfg_d = clock_source_pkg::clk_cfg_t'(io_req.wdata);
            ext_rising = io_req.wdata[`CLK_CFG_EXT_EN_BIT] & ~cfg_q.ext_osc_enable;
        end
        rdata_d = rdata_q;
        rvalid_d = io_req.rd;
        if (io_req.rd)
        begin
            rdata_d = (io_req.addr == `CLK_CFG_ADDR) ? 8'(cfg_q) : 8'h00;
        end
    end

    // Clock switching sequence
    always_comb
    begin
        st_d = st_q;
        load = 1'b0;
        load_val = '0;
        case (st_q)
            clock_source_pkg::ST_INTERNAL:
            begin
                if (ext_rising)
                begin
                    st_d = clock_source_pkg::ST_EXT_START;
                end
                else if (suspend_wake)
                begin
                    st_d = clock_source_pkg::ST_INT_WAKE;
                    load = 1'b1;
                    load_val = CW'(WAKE_DELAY_CYCLES);
                end
            end
            clock_source_pkg::ST_EXT_START:
            begin
                if (ext_clk_stable)
                begin
                    st_d = clock_source_pkg::ST_EXT_DELAY;
                    load = 1'b1;
                    load_val = cfg_q.resume_long ? CW'(LONG_DELAY_CYCLES) : CW'(SHORT_DELAY_CYCLES);
                end
            end
            clock_source_pkg::ST_EXT_DELAY:
            begin
                if (expired)
                begin
                    st_d = clock_source_pkg::ST_EXTERNAL;
                end
            end
            clock_source_pkg::ST_EXTERNAL:
            begin
                if (suspend_wake)
                begin
                    // Bit sampled only on wake-up
                    if (cfg_q.ext_osc_enable)
                    begin
                        st_d = clock_source_pkg::ST_EXT_START;
                    end
                    else
                    begin
                        st_d = clock_source_pkg::ST_INT_WAKE;
                        load = 1'b1;
                        load_val = CW'(WAKE_DELAY_CYCLES);
                    end
                end
            end
            clock_source_pkg::ST_INT_WAKE:
            begin
                if (expired)
                begin
                    st_d = clock_source_pkg::ST_INTERNAL;
                end
            end
            default:
            begin
                st_d = clock_source_pkg::ST_INTERNAL;
            end
        endcase
    end

    // Pin and control outputs from state and register
    always_comb
    begin
        logic ext_mode;
        logic int_mode;
        logic ext_on;
        ext_mode = (st_q == clock_source_pkg::ST_EXT_START) || (st_q == clock_source_pkg::ST_EXT_DELAY)
                   || (st_q == clock_source_pkg::ST_EXTERNAL);
        int_mode = !ext_mode;
        ext_on = ext_mode || cfg_q.ext_osc_enable;
        outs_d[0] = int_mode;
        outs_d[1] = ext_mode;
        outs_d[2] = (st_q == clock_source_pkg::ST_EXT_DELAY) || (st_q == clock_source_pkg::ST_EXTERNAL);
        outs_d[3] = (st_q == clock_source_pkg::ST_INTERNAL) || (st_q == clock_source_pkg::ST_EXTERNAL);
        outs_d[4] = int_mode && cfg_q.precision_usb;
        outs_d[5] = !cfg_q.lvr_disable;
        outs_d[6] = !ext_on && !cfg_q.int_clk_out_disable;
        outs_d[7] = !ext_on;
        outs_d[8] = !ext_on && cfg_q.int_clk_out_disable;
        outs_d[9] = !ext_on && xin_s2_q;
        outs_d[10] = !ext_on && cfg_q.int_clk_out_disable && xout_s2_q;
        outs_d[13:11] = cfg_q.wake_adjust;
        outs_d[14] = 1'b0;
    end

    delay_counter #(
        .WIDTH (CW)
    ) u_delay (
        .clk     (clk),
        .rst     (rst || power_reset),
        .load    (load),
        .count   (load_val),
        .expired (expired)
    );

    // Register all state but the pin synchronisers and the delay counter; power reset forces internal mode
    always_ff @(posedge clk)
    begin
        if (rst || power_reset)
        begin
            cfg_q    <= clock_source_pkg::clk_cfg_t'(`CLK_CFG_RESET);
            st_q     <= clock_source_pkg::ST_INTERNAL;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            outs_q   <= 15'h00E9;
        end
        else if (watchdog_reset)
        begin
            cfg_q    <= clock_source_pkg::clk_cfg_t'(`CLK_CFG_RESET);
            st_q     <= st_d; // Clock sequence keeps running
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            outs_q   <= outs_d;
        end
        else
        begin
            cfg_q    <= cfg_d;
            st_q     <= st_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            outs_q   <= outs_d;
        end
    end

    // Two-stage synchronisers for the oscillator pins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            xin_s1_q  <= 1'b0;
            xin_s2_q  <= 1'b0;
            xout_s1_q <= 1'b0;
            xout_s2_q <= 1'b0;
        end
        else
        begin
            xin_s1_q  <= crystal_input_pin;
            xin_s2_q  <= xin_s1_q;
            xout_s1_q <= crystal_output_pin_in;
            xout_s2_q <= xout_s1_q;
        end
    end

    assign int_osc_enable          = outs_q[0];
    assign ext_osc_run             = outs_q[1];
    assign use_ext_clock           = outs_q[2];
    assign cpu_clock_enable        = outs_q[3];
    assign precision_tune_en       = outs_q[4];
    assign low_volt_reset_en       = outs_q[5];
    assign crystal_output_pin_oe   = outs_q[6];
    assign crystal_input_pulldown  = outs_q[7];
    assign crystal_output_pulldown = outs_q[8];
    assign aux_port_bit1           = outs_q[9];
    assign aux_port_bit2           = outs_q[10];
    assign wake_timer_adjust       = outs_q[13:11];
    assign io_rdata                = rdata_q;
    assign io_rvalid               = rvalid_q;

endmodule : clock_source_config

`default_nettype wire

// ===== common/clock_source_defs.svh
// Offsets, field positions, reset values and timing counts of the clock source block
`ifndef CLOCK_SOURCE_DEFS_SVH
`define CLOCK_SOURCE_DEFS_SVH

`define CLK_CFG_ADDR          8'hF8
`define CPU_STATUS_ADDR       8'hFF
`define CLK_CFG_RESET         8'h00
`define CLK_CFG_EXT_EN_BIT    0
`define CLK_CFG_OUT_DIS_BIT   1
`define CLK_CFG_PREC_BIT      2
`define CLK_CFG_LVR_DIS_BIT   3
`define CLK_CFG_WAKE_LSB      4
`define CLK_CFG_WAKE_MSB      6
`define CLK_CFG_DELAY_BIT     7
`define CLK_FREQ_MHZ          200
`define SHORT_DELAY_US        128
`define LONG_DELAY_MS         4
`define INT_WAKE_DELAY_US     8
`define INT_OSC_START_US      1
`define SHORT_DELAY_CYC       (`SHORT_DELAY_US * `CLK_FREQ_MHZ)
`define LONG_DELAY_CYC        (`LONG_DELAY_MS * 1000 * `CLK_FREQ_MHZ)
`define INT_WAKE_CYC          ((`INT_WAKE_DELAY_US + `INT_OSC_START_US) * `CLK_FREQ_MHZ)

`endif

// ===== common/clock_source_pkg.sv
// Types shared by the clock source block
package clock_source_pkg;

    // Clock switching sequence
    typedef enum logic [2:0] {
        ST_INTERNAL,
        ST_EXT_START,
        ST_EXT_DELAY,
        ST_EXTERNAL,
        ST_INT_WAKE
    } clk_state_t;

    // Decoded view of the configuration register
    typedef struct packed {
        logic       resume_long;
        logic [2:0] wake_adjust;
        logic       lvr_disable;
        logic       precision_usb;
        logic       int_clk_out_disable;
        logic       ext_osc_enable;
    } clk_cfg_t;

    // CPU I/O access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       wr_indexed;
        logic [7:0] addr;
        logic [7:0] x_reg;
        logic [7:0] wdata;
    } io_req_t;

endpackage : clock_source_pkg

// ===== verilog/delay_counter.sv
// Down counter that times the resume delays
`timescale 1ns/1ps
`default_nettype none

module delay_counter #(
    parameter int WIDTH = 20
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  expired
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic             exp_q;
    logic             exp_d;

    // Load, count down, flag when zero reached
    always_comb
    begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (load)
        begin
            cnt_d = count;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
            exp_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    // Register counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;

endmodule : delay_counter

`default_nettype wire

// ===== bench/ext_osc_model.sv
// Behavioural external resonator with a settable start-up time
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model (
    input  wire logic       clk,
    input  wire logic       ext_osc_run,
    input  wire logic [7:0] start_cyc,
    output logic            ext_clk_stable
);
    logic [7:0] cnt_q;
    // Stable only once the element has started; drops when stopped
    always_ff @(posedge clk)
    begin
        cnt_q          <= ext_osc_run ? cnt_q + 8'((cnt_q < start_cyc)) : 8'h00;
        ext_clk_stable <= ext_osc_run && (cnt_q >= start_cyc);
    end
endmodule : ext_osc_model
`default_nettype wire

// ===== bench/clock_source_config_properties.sv
// Port-level checks of the clock source block
`timescale 1ns/1ps
`default_nettype none
module clock_source_config_properties #(
    parameter int LONG_DELAY_CYCLES  = 20,
    parameter int SHORT_DELAY_CYCLES = 10,
    parameter int WAKE_DELAY_CYCLES  = 5
) (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      power_reset,
    input wire logic                      watchdog_reset,
    input wire clock_source_pkg::io_req_t io_req,
    input wire logic [7:0]                io_rdata,
    input wire logic                      io_rvalid,
    input wire logic                      ext_clk_stable,
    input wire logic                      aux_port_bit1,
    input wire logic                      aux_port_bit2,
    input wire logic                      int_osc_enable,
    input wire logic                      ext_osc_run,
    input wire logic                      use_ext_clock,
    input wire logic                      cpu_clock_enable,
    input wire logic                      precision_tune_en,
    input wire logic                      low_volt_reset_en,
    input wire logic [2:0]                wake_timer_adjust
);
    localparam int D_LO = SHORT_DELAY_CYCLES - 1;
    localparam int D_HI = LONG_DELAY_CYCLES - SHORT_DELAY_CYCLES + 8;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || power_reset);
    a_read_answer: assert property (io_req.rd |=> io_rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (io_rvalid |-> $past(io_req.rd))
        else $error("read valid without read");
    a_unmapped_zero: assert property (io_req.rd && io_req.addr != 8'hF8 |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_switch_halts: assert property ($rose(ext_osc_run) |-> !int_osc_enable && !cpu_clock_enable)
        else $error("clocks not halted on switch");
    a_gate_until_stable: assert property (ext_osc_run && !ext_clk_stable |-> !cpu_clock_enable)
        else $error("cpu clocked before stable");
    a_resume_delay: assert property ($rose(ext_clk_stable) && ext_osc_run |->
        (!cpu_clock_enable throughout ##D_LO 1'b1) ##[1:D_HI] cpu_clock_enable)
        else $error("resume delay out of range");
    a_ext_no_gpio: assert property (ext_osc_run |-> !aux_port_bit1 && !aux_port_bit2)
        else $error("aux bits live in external mode");
    a_tune_int_only: assert property (use_ext_clock && $past(use_ext_clock, 2) |-> !precision_tune_en)
        else $error("tuning active on external clock");
    a_cfg_fields: assert property (disable iff (rst || power_reset || watchdog_reset)
        io_req.wr && io_req.addr == 8'hF8 |-> ##2 low_volt_reset_en == !$past(io_req.wdata[3], 2)
        && wake_timer_adjust == $past(io_req.wdata[6:4], 2))
        else $error("config field outputs wrong");
    a_power_internal: assert property (disable iff (rst)
        power_reset |=> int_osc_enable && !ext_osc_run && !use_ext_clock)
        else $error("power reset left external mode");
endmodule : clock_source_config_properties
`default_nettype wire

// ===== bench/clock_source_config_bench.sv
// Directed register and clock switching tests of the clock source block
`timescale 1ns/1ps
`default_nettype none
module clock_source_config_bench;
    localparam int LD = 20;
    localparam int SD = 10;
    localparam int WD = 5;
    logic                      clk, rst, power_reset, watchdog_reset, suspend_wake, xin, xout, stable;
    logic                      rvalid, oe, ipd, opd, aux1, aux2, int_en, ext_run, use_ext, cpu_en, tune, lvr_en;
    logic [7:0]                rdata, start_cyc;
    logic [2:0]                wadj;
    clock_source_pkg::io_req_t req;
    int                        fail_count, n_checks, n;

    clock_source_config #(.LONG_DELAY_CYCLES(LD), .SHORT_DELAY_CYCLES(SD), .WAKE_DELAY_CYCLES(WD)) u_dut (
        .clk(clk), .rst(rst), .power_reset(power_reset), .watchdog_reset(watchdog_reset), .io_req(req),
        .io_rdata(rdata), .io_rvalid(rvalid), .suspend_wake(suspend_wake), .ext_clk_stable(stable),
        .crystal_input_pin(xin), .crystal_output_pin_in(xout), .crystal_output_pin_oe(oe),
        .crystal_input_pulldown(ipd), .crystal_output_pulldown(opd), .aux_port_bit1(aux1), .aux_port_bit2(aux2),
        .int_osc_enable(int_en), .ext_osc_run(ext_run), .use_ext_clock(use_ext), .cpu_clock_enable(cpu_en),
        .precision_tune_en(tune), .low_volt_reset_en(lvr_en), .wake_timer_adjust(wadj));
    ext_osc_model u_osc (.clk(clk), .ext_osc_run(ext_run), .start_cyc(start_cyc), .ext_clk_stable(stable));

    // Clock source
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic ix, input logic [7:0] a, input logic [7:0] x, input logic [7:0] d);
        tick(1);
        req = '{rd: 1'b0, wr: !ix, wr_indexed: ix, addr: a, x_reg: x, wdata: d};
        tick(1);
        req = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        req.rd   = 1'b1;
        req.addr = a;
        tick(1);
        req = '0;
        chk(8'(rvalid), 8'h01);
        chk(rdata, exp);
    endtask : rd

    task automatic switch_time(output int k);
        tick(1);
        chk(8'({int_en, cpu_en}), 8'h00);
        k = 1;
        while (cpu_en !== 1'b1 && k < 100)
        begin
            tick(1);
            k++;
        end
    endtask : switch_time

    // Main sequence
    initial
    begin
        {rst, power_reset, watchdog_reset, suspend_wake, xin, xout} = 6'b100011;
        req        = '0;
        start_cyc  = 8'h05;
        fail_count = 0;
        n_checks   = 0;
        tick(6);
        rst = 1'b0;
        rd(8'hF8, 8'h00);
        tick(1);
        chk({aux1, int_en, cpu_en, lvr_en, oe, ipd, ext_run, use_ext}, 8'hFC);
        wr(1'b0, 8'hF8, 8'h00, 8'h7A);
        rd(8'hF8, 8'h7A);
        chk({2'b00, lvr_en, wadj, oe, opd}, 8'h1D);
        chk(8'({aux1, aux2}), 8'h03);
        xin  = 1'b0;
        xout = 1'b0;
        tick(4);
        chk(8'({aux1, aux2}), 8'h00);
        wr(1'b0, 8'h00, 8'h00, 8'hFF);
        rd(8'hF8, 8'h7A);
        rd(8'h00, 8'h00);
        wr(1'b1, 8'h00, 8'hF8, 8'h04);
        rd(8'hF8, 8'h04);
        chk(8'(tune), 8'h01);
        {xin, xout} = 2'b11;
        wr(1'b1, 8'hF9, 8'hFF, 8'h05);
        switch_time(n);
        chk(8'(n >= SD + 5 && n <= SD + 13), 8'h01);
        chk({4'h0, use_ext, tune, aux1, aux2}, 8'h08);
        wr(1'b0, 8'hF8, 8'h00, 8'h07);
        tick(4);
        chk(8'(cpu_en), 8'h01);
        chk({5'h00, oe, opd, ipd}, 8'h00);
        wr(1'b0, 8'hF8, 8'h00, 8'h04);
        tick(4);
        chk(8'({use_ext, cpu_en}), 8'h03);
        suspend_wake = 1'b1;
        tick(1);
        suspend_wake = 1'b0;
        tick(2);
        chk(8'(cpu_en), 8'h00);
        tick(WD + 4);
        chk(8'({use_ext, int_en, cpu_en}), 8'h03);
        start_cyc = 8'h02;
        wr(1'b0, 8'hF8, 8'h00, 8'h81);
        switch_time(n);
        chk(8'(n >= LD + 2 && n <= LD + 10), 8'h01);
        suspend_wake = 1'b1;
        tick(1);
        suspend_wake = 1'b0;
        switch_time(n);
        chk(8'(n >= LD + 2 && n <= LD + 10), 8'h01);
        watchdog_reset = 1'b1;
        tick(1);
        watchdog_reset = 1'b0;
        rd(8'hF8, 8'h00);
        chk(8'(use_ext), 8'h01);
        power_reset = 1'b1;
        tick(1);
        power_reset = 1'b0;
        tick(2);
        chk(8'({use_ext, ext_run, int_en}), 8'h01);
        stop_test();
    end

    // Hang guard
    initial
    begin
        repeat (3000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule : clock_source_config_bench

bind clock_source_config clock_source_config_properties #(.LONG_DELAY_CYCLES(LONG_DELAY_CYCLES),
    .SHORT_DELAY_CYCLES(SHORT_DELAY_CYCLES), .WAKE_DELAY_CYCLES(WAKE_DELAY_CYCLES)) u_props (
    .clk, .rst, .power_reset, .watchdog_reset, .io_req, .io_rdata, .io_rvalid, .ext_clk_stable,
    .aux_port_bit1, .aux_port_bit2, .int_osc_enable, .ext_osc_run, .use_ext_clock, .cpu_clock_enable,
    .precision_tune_en, .low_volt_reset_en, .wake_timer_adjust);
`default_nettype wire
